//--- src/charger_control_regs_watchdog.sv
// Charger control registers 0x10 to 0x12 with watchdog and ship-FET sequencing.
`timescale 1ns/1ps
`include "charger_ctrl_consts.svh"
module charger_control_regs_watchdog #(
  parameter int TICK_CYCLES = `TICK_CYCLES,
  parameter int SHIP_DELAY_MS = `SHIP_DELAY_MS
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic reg_reset,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic supply_plugged,
  input wire logic detect_done,
  input wire logic input_fet_pair1_drive,
  input wire logic input_fet_pair2_drive,
  output logic line_detect_start,
  output logic line_detect_busy,
  output logic hv_adapter_handshake_enable,
  output logic hv_adapter_twelve_volt_allow,
  output logic hv_adapter_nine_volt_allow,
  output logic [1:0] input_overvoltage_sel,
  output logic watchdog_expired,
  output charger_ctrl_pkg::ship_req_e ship_fet_action,
  output logic ship_fet_action_valid,
  output logic input_fet_pair1_gate_on,
  output logic input_fet_pair2_gate_on,
  output logic reverse_output_enable,
  output logic reverse_pulse_skip_allowed,
  output logic forward_pulse_skip_allowed,
  output logic wake_hold_short,
  output logic linear_precharge_allowed,
  output logic reverse_out_of_audio_limiting,
  output logic forward_out_of_audio_limiting
);
  import charger_ctrl_pkg::*;

  logic [7:0] wdog_ovp_ctrl_ff;
  logic [7:0] detect_ship_ctrl_ff;
  logic [7:0] conv_mode_ctrl_ff;
  logic wr_wdog_ovp;
  logic wr_detect_ship;
  logic wr_conv_mode;
  logic any_reset;
  logic ms_tick;
  logic wdog_expiry;
  logic plugged_ff;
  logic detect_pending_ff;
  logic [13:0] ship_ms_ff;
  ship_state_e ship_state_ff;
  ship_req_e ship_req_latched_ff;

  //////////////////////////////////////////////////////////////////////////////
  // Address decode and write strobes.
  always_comb begin
    wr_wdog_ovp = 1'b0;
    wr_detect_ship = 1'b0;
    wr_conv_mode = 1'b0;
    if (reg_addr == `WDOG_OVP_CTRL_OFS) begin
      wr_wdog_ovp = reg_wr;
    end else if (reg_addr == `DETECT_SHIP_CTRL_OFS) begin
      wr_detect_ship = reg_wr;
    end else if (reg_addr == `CONV_MODE_CTRL_OFS) begin
      wr_conv_mode = reg_wr;
    end
  end
  assign any_reset = srst || reg_reset;

  // Read mux; unmapped offsets read as zero.
  always_comb begin
    if (reg_addr == `WDOG_OVP_CTRL_OFS) begin
      reg_rdata = wdog_ovp_ctrl_ff;
    end else if (reg_addr == `DETECT_SHIP_CTRL_OFS) begin
      reg_rdata = detect_ship_ctrl_ff;
    end else if (reg_addr == `CONV_MODE_CTRL_OFS) begin
      reg_rdata = conv_mode_ctrl_ff;
    end else begin
      reg_rdata = 8'h00;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Watchdog timer; the kick bit is cleared on the same edge that restarts the timer.
  wdog_timer #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_wdog (
    .clk(clk),
    .srst(any_reset),
    .period_sel(wdog_ovp_ctrl_ff[`WDOG_PERIOD_LSB +: 3]),
    .restart(wdog_ovp_ctrl_ff[`WDOG_KICK_BIT]),
    .tick(ms_tick),
    .expired(wdog_expiry)
  );
  assign watchdog_expired = wdog_expiry;

  // Watchdog and overvoltage register; reserved bits 7:6 never store.
  always_ff @(posedge clk) begin
    if (any_reset) begin
      // The reserved bits of the reset word are masked so that they read zero from the start.
      wdog_ovp_ctrl_ff <= `WDOG_OVP_CTRL_RST & `WDOG_OVP_CTRL_WMASK;
    end else if (wr_wdog_ovp) begin
      wdog_ovp_ctrl_ff <= reg_wdata & `WDOG_OVP_CTRL_WMASK;
    end else if (wdog_expiry) begin
      wdog_ovp_ctrl_ff <= (wdog_ovp_ctrl_ff & ~`WDOG_OVP_CTRL_WDMASK)
                          | (`WDOG_OVP_CTRL_RST & `WDOG_OVP_CTRL_WDMASK);
    end else if (wdog_ovp_ctrl_ff[`WDOG_KICK_BIT]) begin
      wdog_ovp_ctrl_ff[`WDOG_KICK_BIT] <= 1'b0;
    end
  end
  assign input_overvoltage_sel = wdog_ovp_ctrl_ff[`OVP_SEL_LSB +: 2];

  //////////////////////////////////////////////////////////////////////////////
  // Supply plug-in edge for automatic detection.
  always_ff @(posedge clk) begin
    if (srst) begin
      plugged_ff <= 1'b0;
    end else begin
      plugged_ff <= supply_plugged;
    end
  end

  // Detection runs from a forced request or an enabled plug-in until done.
  always_ff @(posedge clk) begin
    if (any_reset || wdog_expiry) begin
      detect_pending_ff <= 1'b0;
    end else if (line_detect_start) begin
      detect_pending_ff <= 1'b1;
    end else if (detect_done) begin
      detect_pending_ff <= 1'b0;
    end
  end
  assign line_detect_start = !detect_pending_ff && ((wr_detect_ship
      && reg_wdata[`FORCED_DETECT_BIT])
      || (supply_plugged && !plugged_ff
      && detect_ship_ctrl_ff[`AUTO_DETECT_BIT]));
  assign line_detect_busy = detect_pending_ff;

  // Detection and ship register; a fresh force write wins over a done pulse.
  always_ff @(posedge clk) begin
    if (any_reset) begin
      detect_ship_ctrl_ff <= `DETECT_SHIP_CTRL_RST;
    end else if (wr_detect_ship) begin
      detect_ship_ctrl_ff <= reg_wdata;
    end else if (wdog_expiry) begin
      detect_ship_ctrl_ff <= (detect_ship_ctrl_ff & ~`DETECT_SHIP_CTRL_WDMASK)
                             | (`DETECT_SHIP_CTRL_RST & `DETECT_SHIP_CTRL_WDMASK);
    end else if (detect_done && detect_pending_ff) begin
      detect_ship_ctrl_ff[`FORCED_DETECT_BIT] <= 1'b0;
    end
  end
  assign hv_adapter_handshake_enable = detect_ship_ctrl_ff[`HANDSHAKE_EN_BIT];
  assign hv_adapter_twelve_volt_allow = detect_ship_ctrl_ff[`HANDSHAKE_EN_BIT]
                                        && detect_ship_ctrl_ff[`TWELVE_ALLOW_BIT];
  assign hv_adapter_nine_volt_allow = detect_ship_ctrl_ff[`HANDSHAKE_EN_BIT]
                                      && detect_ship_ctrl_ff[`NINE_ALLOW_BIT];

  //////////////////////////////////////////////////////////////////////////////
  // Ship-FET sequencer; a change of request restarts the wait.
  always_ff @(posedge clk) begin
    if (any_reset) begin
      ship_state_ff <= SHIP_IDLE;
      ship_req_latched_ff <= SHIP_REQ_NONE;
      ship_ms_ff <= 14'h0;
    end else begin
      case (ship_state_ff)
        SHIP_IDLE: begin
          ship_ms_ff <= 14'h0;
          ship_req_latched_ff <= ship_req_e'(detect_ship_ctrl_ff[`SHIP_REQ_LSB +: 2]);
          if (detect_ship_ctrl_ff[`SHIP_REQ_LSB +: 2] != 2'h0) begin
            ship_state_ff <= detect_ship_ctrl_ff[`SHIP_DELAY_SKIP_BIT]
                             ? SHIP_ACT : SHIP_WAIT;
          end
        end
        SHIP_WAIT: begin
          if (detect_ship_ctrl_ff[`SHIP_REQ_LSB +: 2] != ship_req_latched_ff) begin
            ship_state_ff <= SHIP_IDLE;
          end else if (ms_tick) begin
            ship_ms_ff <= ship_ms_ff + 14'h1;
            if (ship_ms_ff >= 14'(SHIP_DELAY_MS - 1)) begin
              ship_state_ff <= SHIP_ACT;
            end
          end
        end
        SHIP_ACT: begin
          ship_state_ff <= SHIP_DONE;
        end
        SHIP_DONE: begin
          if (detect_ship_ctrl_ff[`SHIP_REQ_LSB +: 2] != ship_req_latched_ff) begin
            ship_state_ff <= SHIP_IDLE;
          end
        end
        default: begin
          ship_state_ff <= SHIP_IDLE;
        end
      endcase
    end
  end
  assign ship_fet_action_valid = (ship_state_ff == SHIP_ACT);
  assign ship_fet_action = ship_req_latched_ff;

  //////////////////////////////////////////////////////////////////////////////
  // Converter mode register; bit 7 is reset only by srst or reg_reset, not by watchdog expiry.
  always_ff @(posedge clk) begin
    if (any_reset) begin
      conv_mode_ctrl_ff <= `CONV_MODE_CTRL_RST;
    end else if (wr_conv_mode) begin
      conv_mode_ctrl_ff <= reg_wdata;
    end else if (wdog_expiry) begin
      conv_mode_ctrl_ff <= (conv_mode_ctrl_ff & ~`CONV_MODE_CTRL_WDMASK)
                           | (`CONV_MODE_CTRL_RST & `CONV_MODE_CTRL_WDMASK);
    end
  end

  // The disable bit overrides the two per-pair drive bits.
  assign input_fet_pair1_gate_on = input_fet_pair1_drive
                                   && !conv_mode_ctrl_ff[`FET_DRV_DISABLE_BIT];
  assign input_fet_pair2_gate_on = input_fet_pair2_drive
                                   && !conv_mode_ctrl_ff[`FET_DRV_DISABLE_BIT];
  assign reverse_output_enable = conv_mode_ctrl_ff[`REVERSE_EN_BIT];
  assign reverse_pulse_skip_allowed = !conv_mode_ctrl_ff[`REV_PSKIP_DIS_BIT];
  assign forward_pulse_skip_allowed = !conv_mode_ctrl_ff[`FWD_PSKIP_DIS_BIT];
  assign wake_hold_short = conv_mode_ctrl_ff[`WAKE_SEL_BIT];
  assign linear_precharge_allowed = !conv_mode_ctrl_ff[`LINEAR_DIS_BIT];
  assign reverse_out_of_audio_limiting = !conv_mode_ctrl_ff[`REV_OOA_DIS_BIT];
  assign forward_out_of_audio_limiting = !conv_mode_ctrl_ff[`FWD_OOA_DIS_BIT];

  //////////////////////////////////////////////////////////////////////////////
  // Assertions.
  sequence kick_write_s;
    wr_wdog_ovp && reg_wdata[`WDOG_KICK_BIT];
  endsequence
  sequence kick_cleared_s;
    wdog_ovp_ctrl_ff[`WDOG_KICK_BIT] ##1 !wdog_ovp_ctrl_ff[`WDOG_KICK_BIT];
  endsequence

  kick_self_clear_a: assert property (@(posedge clk) disable iff (any_reset)
    kick_write_s ##1 !wr_wdog_ovp |-> kick_cleared_s)
    else $error("Kick bit did not self-clear.");
  period_reset_val_a: assert property (@(posedge clk)
    $past(srst) && !srst |-> wdog_ovp_ctrl_ff[2:0] == 3'h5)
    else $error("Watchdog period reset value wrong.");
  forced_detect_a: assert property (@(posedge clk) disable iff (any_reset)
    !detect_pending_ff && wr_detect_ship && reg_wdata[`FORCED_DETECT_BIT]
    |-> line_detect_start ##1 detect_pending_ff)
    else $error("Forced detection did not start.");
  auto_detect_a: assert property (@(posedge clk) disable iff (any_reset)
    line_detect_start && !wr_detect_ship |-> detect_ship_ctrl_ff[`AUTO_DETECT_BIT])
    else $error("Detection ran with auto detect off.");
  twelve_volt_a: assert property (@(posedge clk) disable iff (srst)
    hv_adapter_twelve_volt_allow |-> hv_adapter_handshake_enable)
    else $error("Twelve volt allowed without handshake.");
  ship_delay_a: assert property (@(posedge clk) disable iff (any_reset)
    ship_state_ff == SHIP_IDLE && detect_ship_ctrl_ff[2:1] != 2'h0
    && !detect_ship_ctrl_ff[`SHIP_DELAY_SKIP_BIT] |=> ship_state_ff == SHIP_WAIT)
    else $error("Ship request skipped the delay.");
  fet_disable_a: assert property (@(posedge clk) disable iff (srst)
    conv_mode_ctrl_ff[`FET_DRV_DISABLE_BIT]
    |-> !input_fet_pair1_gate_on && !input_fet_pair2_gate_on)
    else $error("FET drive active while disabled.");
  wdog_keep_a: assert property (@(posedge clk) disable iff (any_reset)
    wdog_expiry && !wr_conv_mode |=> conv_mode_ctrl_ff[7] == $past(conv_mode_ctrl_ff[7])
    && conv_mode_ctrl_ff[6] == 1'b0)
    else $error("Watchdog expiry reset the wrong fields.");
  reserved_zero_a: assert property (@(posedge clk) disable iff (srst)
    wdog_ovp_ctrl_ff[7:6] == 2'h0)
    else $error("Reserved bits are not zero.");
  ship_pulse_a: assert property (@(posedge clk) disable iff (any_reset)
    ship_fet_action_valid |=> !ship_fet_action_valid)
    else $error("Ship action pulse lasted more than one cycle.");
  detect_clear_a: assert property (@(posedge clk) disable iff (any_reset)
    detect_done && detect_pending_ff && !wr_detect_ship && !wdog_expiry
    |=> !detect_pending_ff && !detect_ship_ctrl_ff[`FORCED_DETECT_BIT])
    else $error("Forced detect bit not cleared after done.");
  // Expiry must force the detection bits back to their reset pattern.
  expiry_fields_a: assert property (@(posedge clk) disable iff (any_reset)
    wdog_expiry && !wr_detect_ship |=> detect_ship_ctrl_ff[7:6] == 2'h1)
    else $error("Watchdog expiry left detection fields unchanged.");
  fet_follow_a: assert property (@(posedge clk) disable iff (srst)
    !conv_mode_ctrl_ff[`FET_DRV_DISABLE_BIT]
    |-> input_fet_pair1_gate_on == input_fet_pair1_drive
    && input_fet_pair2_gate_on == input_fet_pair2_drive)
    else $error("FET gate does not follow its drive bit.");
  // A register reset pulse leaves every register at its reset word, with reserved bits masked, one edge later.
  reg_reset_vals_a: assert property (@(posedge clk)
    reg_reset |=> wdog_ovp_ctrl_ff == (`WDOG_OVP_CTRL_RST & `WDOG_OVP_CTRL_WMASK)
    && detect_ship_ctrl_ff == `DETECT_SHIP_CTRL_RST
    && conv_mode_ctrl_ff == `CONV_MODE_CTRL_RST)
    else $error("Register reset left a register off its reset value.");
endmodule : charger_control_regs_watchdog

//--- src/charger_ctrl_consts.svh
// Register offsets, field positions, reset values and timing constants.
`ifndef CHARGER_CTRL_CONSTS_SVH
`define CHARGER_CTRL_CONSTS_SVH
`define WDOG_OVP_CTRL_OFS 8'h10
`define DETECT_SHIP_CTRL_OFS 8'h11
`define CONV_MODE_CTRL_OFS 8'h12
`define WDOG_OVP_CTRL_RST 8'h85
`define DETECT_SHIP_CTRL_RST 8'h40
`define CONV_MODE_CTRL_RST 8'h00
`define WDOG_OVP_CTRL_WMASK 8'h3F
`define WDOG_KICK_BIT 3
`define WDOG_PERIOD_LSB 0
`define OVP_SEL_LSB 4
`define FORCED_DETECT_BIT 7
`define AUTO_DETECT_BIT 6
`define TWELVE_ALLOW_BIT 5
`define NINE_ALLOW_BIT 4
`define HANDSHAKE_EN_BIT 3
`define SHIP_REQ_LSB 1
`define SHIP_DELAY_SKIP_BIT 0
`define FET_DRV_DISABLE_BIT 7
`define REVERSE_EN_BIT 6
`define REV_PSKIP_DIS_BIT 5
`define FWD_PSKIP_DIS_BIT 4
`define WAKE_SEL_BIT 3
`define LINEAR_DIS_BIT 2
`define REV_OOA_DIS_BIT 1
`define FWD_OOA_DIS_BIT 0
// Bits of each register returned to their reset values on watchdog expiry.
`define WDOG_OVP_CTRL_WDMASK 8'h08
`define DETECT_SHIP_CTRL_WDMASK 8'hC0
`define CONV_MODE_CTRL_WDMASK 8'h66
// Times in their own units.
`define CLK_MHZ 100
`define TICK_MS 1
`define TICK_CYCLES (`TICK_MS * `CLK_MHZ * 1000)
`define SHIP_DELAY_MS 10000
`define WDOG_HALF_S_MS 500
`define WDOG_1_S_MS 1000
`define WDOG_2_S_MS 2000
`define WDOG_20_S_MS 20000
`define WDOG_40_S_MS 40000
`define WDOG_80_S_MS 80000
`define WDOG_160_S_MS 160000
`endif

//--- src/charger_ctrl_pkg.sv
// Types shared by the charger control register bank.
package charger_ctrl_pkg;
  typedef enum logic [3:0] {
    SHIP_IDLE = 4'b0001,
    SHIP_WAIT = 4'b0010,
    SHIP_ACT = 4'b0100,
    SHIP_DONE = 4'b1000
  } ship_state_e;
  typedef enum logic [1:0] {
    SHIP_REQ_NONE = 2'h0,
    SHIP_REQ_SHUTDOWN = 2'h1,
    SHIP_REQ_SHIP = 2'h2,
    SHIP_REQ_POWER_RESET = 2'h3
  } ship_req_e;
endpackage : charger_ctrl_pkg

//--- src/wdog_timer.sv
// Host-communication watchdog timer counting millisecond ticks.
`timescale 1ns/1ps
`include "charger_ctrl_consts.svh"
module wdog_timer #(
  parameter int TICK_CYCLES = `TICK_CYCLES
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic [2:0] period_sel,
  input wire logic restart,
  output logic tick,
  output logic expired
);
  logic [31:0] div_ff;
  logic [17:0] ms_ff;
  logic [17:0] limit;

  // Millisecond enable from the system clock.
  always_ff @(posedge clk) begin
    if (srst || div_ff == TICK_CYCLES - 1) begin
      div_ff <= 32'h0;
    end else begin
      div_ff <= div_ff + 32'h1;
    end
  end
  assign tick = (div_ff == TICK_CYCLES - 1);

  // Period select decode; code zero stops the timer.
  always_comb begin
    case (period_sel)
      3'h1: limit = 18'(`WDOG_HALF_S_MS);
      3'h2: limit = 18'(`WDOG_1_S_MS);
      3'h3: limit = 18'(`WDOG_2_S_MS);
      3'h4: limit = 18'(`WDOG_20_S_MS);
      3'h5: limit = 18'(`WDOG_40_S_MS);
      3'h6: limit = 18'(`WDOG_80_S_MS);
      3'h7: limit = 18'(`WDOG_160_S_MS);
      default: limit = 18'h0;
    endcase
  end

  // Elapsed time; a kick or expiry starts it over.
  always_ff @(posedge clk) begin
    if (srst || restart || expired || period_sel == 3'h0) begin
      ms_ff <= 18'h0;
    end else if (tick) begin
      ms_ff <= ms_ff + 18'h1;
    end
  end
  assign expired = (period_sel != 3'h0) && (ms_ff >= limit);
endmodule : wdog_timer

//--- testbench/charger_control_regs_watchdog_bench.sv
// Self-checking bench for the charger control register bank.
`timescale 1ns/1ps
module charger_control_regs_watchdog_bench;
  import charger_ctrl_pkg::*;
  localparam int TICK = 10;
  localparam int SHIP_MS = 3;
  localparam int LIMIT = 40000;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic reg_reset = 1'b0;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, rd_val, v;
  logic reg_wr, supply_plugged, detect_done, drv1, drv2, busy, start, hs, twelve, nine;
  logic expired, act_valid, g1, g2, rev_en, rps, fps, wake, lin, rooa, fooa;
  logic [1:0] ovp;
  ship_req_e act;
  // Reserved bits 7:6 of the first register read zero, so its reset word reads with them clear.
  logic [7:0] rv [4] = '{8'h05, 8'h40, 8'h00, 8'h00};
  logic [7:0] wd [3] = '{8'h21, 8'h78, 8'h99};
  int fails = 0;
  int tests_run = 0;
  int cycles = 0;
  int n;

  // Short tick and ship delay keep the watchdog and ship waits to a few thousand cycles.
  charger_control_regs_watchdog #(.TICK_CYCLES(TICK), .SHIP_DELAY_MS(SHIP_MS)) u_dut (
    .clk(clk), .srst(srst), .reg_reset(reg_reset), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .supply_plugged(supply_plugged),
    .detect_done(detect_done), .input_fet_pair1_drive(drv1), .input_fet_pair2_drive(drv2),
    .line_detect_start(start), .line_detect_busy(busy), .hv_adapter_handshake_enable(hs),
    .hv_adapter_twelve_volt_allow(twelve), .hv_adapter_nine_volt_allow(nine),
    .input_overvoltage_sel(ovp), .watchdog_expired(expired), .ship_fet_action(act),
    .ship_fet_action_valid(act_valid), .input_fet_pair1_gate_on(g1),
    .input_fet_pair2_gate_on(g2), .reverse_output_enable(rev_en),
    .reverse_pulse_skip_allowed(rps), .forward_pulse_skip_allowed(fps),
    .wake_hold_short(wake), .linear_precharge_allowed(lin),
    .reverse_out_of_audio_limiting(rooa), .forward_out_of_audio_limiting(fooa)
  );
  host_model host (.clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata));

  // Free-running clock and a cycle ceiling that cuts a hang short.
  always #5 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      fails++;
      summarize();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Compares two values and counts the outcome.
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  // Prints the counts and the verdict, then ends the run.
  task automatic summarize;
    $display("checks %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : summarize
  // Counts falling edges until the ship pulse (0) or watchdog pulse (1) shows, bounded.
  task automatic wait_flag(input int which, input int lim, output int cnt);
    cnt = 0;
    while (cnt < lim && (which == 1 ? expired : act_valid) !== 1'b1) begin
      @(negedge clk);
      cnt++;
    end
  endtask : wait_flag
  // Pulses the detection-complete input for one cycle and lets the clear land.
  task automatic end_detect;
    @(negedge clk);
    detect_done = 1'b1;
    @(negedge clk);
    detect_done = 1'b0;
    @(negedge clk);
  endtask : end_detect
  // Expected converter outputs: the disable bit overrides both gate drives.
  function automatic logic [15:0] exp_conv(input logic [7:0] r, input logic d1, input logic d2);
    return {7'h00, d1 & ~r[7], d2 & ~r[7], r[6], ~r[5], ~r[4], r[3], ~r[2], ~r[1], ~r[0]};
  endfunction : exp_conv

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence: reset, field tests, detection, ship requests, watchdog, register reset.
  initial begin
    supply_plugged = 1'b0;
    detect_done = 1'b0;
    drv1 = 1'b0;
    drv2 = 1'b0;
    n = $urandom(11);
    repeat (2) @(negedge clk);
    srst = 1'b0;
    host.wr(8'h13, 8'hFF);
    for (int i = 0; i < 4; i++) begin
      host.rd(8'h10 + 8'(i), rd_val);
      check(16'(rd_val), 16'(rv[i]));
    end
    $display("test reset values done");
    for (int i = 0; i < 6; i++) begin
      v = 8'($urandom) | 8'h0F;
      host.wr(8'h10, v);
      host.rd(8'h10, rd_val);
      check(16'(rd_val), 16'(v & 8'h37));
      check(16'(ovp), 16'(v[5:4]));
      v = 8'($urandom) & 8'h79;
      host.wr(8'h11, v);
      host.rd(8'h11, rd_val);
      check(16'(rd_val), 16'(v));
      check(16'({hs, twelve, nine}), 16'({v[3], v[5] & v[3], v[4] & v[3]}));
      v = (i == 0) ? 8'h80 : 8'($urandom);
      drv1 = (i == 0) | 1'($urandom);
      drv2 = (i == 0) | 1'($urandom);
      host.wr(8'h12, v);
      host.rd(8'h12, rd_val);
      check(16'(rd_val), 16'(v));
      check({7'h00, g1, g2, rev_en, rps, fps, wake, lin, rooa, fooa}, exp_conv(v, drv1, drv2));
    end
    $display("test field outputs done");
    host.wr(8'h11, 8'h80);
    host.rd(8'h11, rd_val);
    check(16'({busy, rd_val}), 16'h0180);
    end_detect();
    host.rd(8'h11, rd_val);
    check(16'({busy, rd_val}), 16'h0000);
    // A plug-in starts detection only while automatic detection is on.
    for (int i = 1; i >= 0; i--) begin
      host.wr(8'h11, i == 1 ? 8'h40 : 8'h00);
      @(negedge clk);
      supply_plugged = 1'b1;
      #1 check(16'(start), 16'(i));
      repeat (2) @(negedge clk);
      check(16'(busy), 16'(i));
      end_detect();
      supply_plugged = 1'b0;
    end
    $display("test detection done");
    for (int c = 1; c < 4; c++) begin
      host.wr(8'h11, {5'h00, 2'(c), 1'b1});
      wait_flag(0, 10, n);
      check(16'({act, 1'(n <= 3)}), 16'({2'(c), 1'b1}));
      host.wr(8'h11, 8'h00);
      repeat (3) @(negedge clk);
    end
    host.wr(8'h11, 8'h04);
    wait_flag(0, 100, n);
    check(16'({act, 1'(n >= 2 * TICK && n <= (SHIP_MS + 1) * TICK)}), 16'h0005);
    $display("test ship requests done");
    // A kick part-way through must push expiry a full half-second period out.
    host.wr(8'h12, 8'hFF);
    host.wr(8'h11, 8'h38);
    host.wr(8'h10, 8'h21);
    repeat (300 * TICK) @(negedge clk);
    host.wr(8'h10, 8'h29);
    wait_flag(1, 600 * TICK, n);
    check(16'(n >= 490 * TICK && n <= 510 * TICK), 16'h0001);
    for (int i = 0; i < 3; i++) begin
      host.rd(8'h10 + 8'(i), rd_val);
      check(16'(rd_val), 16'(wd[i]));
    end
    $display("test watchdog done");
    @(negedge clk);
    reg_reset = 1'b1;
    @(negedge clk);
    reg_reset = 1'b0;
    for (int i = 0; i < 3; i++) begin
      host.rd(8'h10 + 8'(i), rd_val);
      check(16'(rd_val), 16'(rv[i]));
    end
    $display("test register reset done");
    summarize();
  end
endmodule : charger_control_regs_watchdog_bench

//--- testbench/host_model.sv
// Host model that reaches the control registers through the byte-wide register port.
`timescale 1ns/1ps
module host_model (
  input wire logic clk,
  output logic [7:0] reg_addr,
  output logic reg_wr,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata
);
  // The host idles with no strobe until its first transfer.
  initial begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_wdata = 8'h00;
  end
  // One strobe cycle per byte; afterwards the data lines show the inverse so stale data never helps.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
    reg_wdata = ~d;
  endtask : wr
  // Read data is combinational, so it is taken once the address has settled.
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    #1 d = reg_rdata;
  endtask : rd
endmodule : host_model
